//--- inc/rcd_pkg.sv
/*
 * Constants for the reference clock divider: register map, control field
 * layout, reset values, duty codes and bus response codes.
 * Assumes a 32-bit AXI4-Lite slave with byte addresses and one register a word.
 */
package rcd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map (byte addresses)
    localparam int unsigned ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;

    ////////////////////////////////////////////////////////////////////////
    // control register fields
    localparam int unsigned CTRL_W = 8;
    localparam int unsigned CTRL_EN_BIT = 7;
    localparam int unsigned CTRL_OE_BIT = 6;
    localparam int unsigned CTRL_SLR_BIT = 5;
    localparam int unsigned CTRL_DC_LSB = 3;
    localparam int unsigned DC_W = 2;
    localparam int unsigned CTRL_DIV_LSB = 0;
    localparam int unsigned DIV_W = 3;
    // slew limiting on, duty 50 %, everything else off
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h30;

    ////////////////////////////////////////////////////////////////////////
    // status register fields
    localparam int unsigned STAT_LEVEL_BIT = 0;
    localparam int unsigned STAT_PIN_REF_BIT = 1;
    localparam int unsigned STAT_PIN_LEGACY_BIT = 2;
    localparam int unsigned STAT_PIN_OSC_BIT = 3;
    localparam int unsigned STAT_RUN_BIT = 4;

    ////////////////////////////////////////////////////////////////////////
    // duty codes and divider
    localparam logic [DC_W-1:0] DUTY_0 = 2'h0;
    localparam logic [DC_W-1:0] DUTY_25 = 2'h1;
    localparam logic [DC_W-1:0] DUTY_50 = 2'h2;
    localparam logic [DC_W-1:0] DUTY_75 = 2'h3;
    localparam logic [DIV_W-1:0] DIV_BY_1 = 3'h0;
    localparam logic [DIV_W-1:0] DIV_BY_2 = 3'h1;
    localparam int unsigned CNT_W = 8;
    localparam int unsigned LEGACY_CNT_W = 2;

    ////////////////////////////////////////////////////////////////////////
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // who owns the shared pin
    typedef enum logic [1:0] {PIN_IDLE, PIN_OSC, PIN_LEGACY, PIN_REF} rcd_pin_src_t;

endpackage

//--- logic/rcd_top.sv
/*
 * Reference clock divider: divides the system clock by a power of two,
 * shapes its duty cycle, feeds the signal modulator and, when allowed,
 * the shared oscillator/reference pin. Control over AXI4-Lite.
 * Assumes aclk is the system clock, the pin pad and the oscillator sit
 * outside, and configuration/sleep levels are synchronous to aclk.
 */
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rcd_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [rcd_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [rcd_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // device configuration and power state
    input wire logic low_power_crystal_mode,
    input wire logic standard_crystal_mode,
    input wire logic high_speed_crystal_mode,
    input wire logic legacy_clock_out_select,
    input wire logic sleep_active,
    // shared oscillator / reference pin
    output logic ref_clock_pin,
    output logic ref_clock_pin_oe_n,
    output logic ref_slew_limit_enable,
    // secondary clock to the modulator
    output logic ref_mod_clock
);
    import rcd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // high time, in system clock cycles, for a divider and duty code
    function automatic logic [CNT_W-1:0] duty_high(input logic [DIV_W-1:0] div,
                                                   input logic [DC_W-1:0] dc);
        logic [CNT_W-1:0] period;
        period = CNT_W'(1) << div;
        if (div == DIV_BY_2) begin
            // half period; the quarter steps come from the clock phase
            duty_high = (dc == DUTY_0) ? '0 : CNT_W'(1);
        end else begin
            unique case (dc)
                DUTY_0: duty_high = '0;
                DUTY_25: duty_high = period >> 2;
                DUTY_50: duty_high = period >> 1;
                DUTY_75: duty_high = period - (period >> 2);
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // control register and its fields
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic module_en;
    logic pin_oe_bit;
    logic [DC_W-1:0] ref_duty_select;
    logic [DIV_W-1:0] ref_divider_select;

    // field decode
    assign module_en = ctrl_q[CTRL_EN_BIT];
    assign pin_oe_bit = ctrl_q[CTRL_OE_BIT];
    assign ref_duty_select = ctrl_q[CTRL_DC_LSB +: DC_W];
    assign ref_divider_select = ctrl_q[CTRL_DIV_LSB +: DIV_W];

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write side: address and data taken in either order
    logic aw_got_q, aw_got_d;
    logic w_got_q, w_got_d;
    logic [ADDR_W-1:0] waddr_q, waddr_d;
    logic [CTRL_W-1:0] wbyte_q, wbyte_d;
    logic wlane_q, wlane_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;

    // one write in flight; channels close until the response is taken
    assign awready = !aw_got_q && !bvalid_q;
    assign wready = !w_got_q && !bvalid_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;

    // write next-state, including the register update
    always_comb begin
        logic aw_now;
        logic w_now;
        logic [ADDR_W-1:0] addr;
        logic [CTRL_W-1:0] data;
        logic lane;
        aw_now = aw_got_q || (awvalid && awready);
        w_now = w_got_q || (wvalid && wready);
        addr = aw_got_q ? waddr_q : awaddr;
        data = w_got_q ? wbyte_q : wdata[CTRL_W-1:0];
        lane = w_got_q ? wlane_q : wstrb[0];
        aw_got_d = aw_now;
        w_got_d = w_now;
        waddr_d = (awvalid && awready) ? awaddr : waddr_q;
        wbyte_d = (wvalid && wready) ? wdata[CTRL_W-1:0] : wbyte_q;
        wlane_d = (wvalid && wready) ? wstrb[0] : wlane_q;
        bvalid_d = bvalid_q && !bready;
        bresp_d = bresp_q;
        ctrl_d = ctrl_q;
        if (aw_now && w_now && !bvalid_q) begin
            aw_got_d = 1'b0;
            w_got_d = 1'b0;
            bvalid_d = 1'b1;
            if (addr == ADDR_CONTROL) begin
                bresp_d = RESP_OKAY;
                if (lane) begin
                    ctrl_d = data;
                end
            end else if (addr == ADDR_STATUS) begin
                bresp_d = RESP_OKAY; // status is read-only, write dropped
            end else begin
                bresp_d = RESP_SLVERR;
            end
        end
    end

    // write registers; any reset restores the control defaults
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RESET;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            waddr_q <= '0;
            wbyte_q <= '0;
            wlane_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            ctrl_q <= ctrl_d;
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            waddr_q <= waddr_d;
            wbyte_q <= wbyte_d;
            wlane_q <= wlane_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // divider: counter and registered waveform
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic wave_q, wave_d;
    logic hold_q, hold_d;
    logic running;
    logic ref_level_live;

    // sleep stops the generator whatever the clock source
    assign running = module_en && !sleep_active;

    // counter wraps at the period; a shrinking period wraps at once
    always_comb begin
        logic [CNT_W-1:0] period;
        period = CNT_W'(1) << ref_divider_select;
        cnt_d = cnt_q;
        wave_d = wave_q;
        hold_d = hold_q;
        if (!module_en) begin
            cnt_d = '0;
            wave_d = 1'b0;
            hold_d = 1'b0;
        end else if (running) begin
            cnt_d = (cnt_q >= period - CNT_W'(1)) ? '0 : cnt_q + CNT_W'(1);
            wave_d = cnt_d < duty_high(ref_divider_select, ref_duty_select);
            hold_d = ref_level_live;
        end
    end

    // generator state; sleep leaves it untouched
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
            wave_q <= 1'b0;
            hold_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            wave_q <= wave_d;
            hold_q <= hold_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output shaping: the two fastest ratios use the clock level itself,
    // so their quarter steps track the source duty and are not exact
    logic ref_level;

    always_comb begin
        ref_level_live = wave_q;
        if (ref_divider_select == DIV_BY_1) begin
            ref_level_live = module_en && (ref_duty_select != DUTY_0) && aclk;
        end else if (ref_divider_select == DIV_BY_2) begin
            unique case (ref_duty_select)
                DUTY_25: ref_level_live = wave_q && aclk;
                DUTY_75: ref_level_live = wave_q || aclk;
                default: ref_level_live = wave_q;
            endcase
        end
    end

    // sleep shows the level held from the last running cycle
    assign ref_level = sleep_active ? hold_q : ref_level_live;
    // modulator sees the clock whatever happens at the pin
    assign ref_mod_clock = ref_level;

    ////////////////////////////////////////////////////////////////////////
    // legacy clock-out: system clock divided by four
    logic [LEGACY_CNT_W-1:0] leg_cnt_q, leg_cnt_d;

    // frozen in sleep like the rest of the clock tree
    assign leg_cnt_d = sleep_active ? leg_cnt_q : leg_cnt_q + LEGACY_CNT_W'(1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            leg_cnt_q <= '0;
        end else begin
            leg_cnt_q <= leg_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin ownership: oscillator first, then legacy clock-out, then us
    rcd_pin_src_t pin_src_q, pin_src_d;
    logic crystal_mode;

    assign crystal_mode = low_power_crystal_mode || standard_crystal_mode
                          || high_speed_crystal_mode;

    always_comb begin
        if (crystal_mode) begin
            pin_src_d = PIN_OSC;
        end else if (!legacy_clock_out_select) begin
            pin_src_d = PIN_LEGACY;
        end else if (module_en && pin_oe_bit) begin
            pin_src_d = PIN_REF;
        end else begin
            pin_src_d = PIN_IDLE;
        end
    end

    // registered so the pin driver never glitches on a config change
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_src_q <= PIN_IDLE;
        end else begin
            pin_src_q <= pin_src_d;
        end
    end

    // pin data and enable; the enable is low while we drive
    always_comb begin
        unique case (pin_src_q)
            PIN_OSC: begin
                ref_clock_pin = 1'b0;
                ref_clock_pin_oe_n = 1'b1;
            end
            PIN_LEGACY: begin
                ref_clock_pin = leg_cnt_q[LEGACY_CNT_W-1];
                ref_clock_pin_oe_n = 1'b0;
            end
            PIN_REF: begin
                ref_clock_pin = ref_level;
                ref_clock_pin_oe_n = 1'b0;
            end
            PIN_IDLE: begin
                ref_clock_pin = 1'b0;
                ref_clock_pin_oe_n = 1'b1;
            end
        endcase
    end

    // slew limiting straight from the control bit
    assign ref_slew_limit_enable = ctrl_q[CTRL_SLR_BIT];

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read side
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] status_word;

    assign arready = !rvalid_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    // live state of the generator and of the pin
    always_comb begin
        status_word = '0;
        status_word[STAT_LEVEL_BIT] = wave_q;
        status_word[STAT_PIN_REF_BIT] = (pin_src_q == PIN_REF);
        status_word[STAT_PIN_LEGACY_BIT] = (pin_src_q == PIN_LEGACY);
        status_word[STAT_PIN_OSC_BIT] = (pin_src_q == PIN_OSC);
        status_word[STAT_RUN_BIT] = running;
    end

    // read next-state; unmapped addresses answer slverr with zero data
    always_comb begin
        rvalid_d = rvalid_q && !rready;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (arvalid && arready) begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            if (araddr == ADDR_CONTROL) begin
                rdata_d = {{(32-CTRL_W){1'b0}}, ctrl_q};
            end else if (araddr == ADDR_STATUS) begin
                rdata_d = status_word;
            end else begin
                rdata_d = '0;
                rresp_d = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else begin
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

endmodule
`default_nettype wire

//--- verif/rcd_top_sva.sv
/* port assertions for rcd_top
   assumes address and data are offered together */
`timescale 1ns/1ps
`default_nettype none
module rcd_top_sva
    import rcd_pkg::*;
(
    // clock, reset
    input wire logic aclk,
    input wire logic aresetn,
    // write channels
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [rcd_pkg::ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // configuration
    input wire logic low_power_crystal_mode,
    input wire logic standard_crystal_mode,
    input wire logic high_speed_crystal_mode,
    input wire logic legacy_clock_out_select,
    input wire logic sleep_active,
    // outputs
    input wire logic ref_clock_pin,
    input wire logic ref_clock_pin_oe_n,
    input wire logic ref_slew_limit_enable,
    input wire logic ref_mod_clock
);
    import rcd_pkg::*;
    logic xtal;
    logic [CTRL_W-1:0] sh_q;
    logic [CTRL_W-1:0] sh_d;
    assign xtal = low_power_crystal_mode | standard_crystal_mode | high_speed_crystal_mode;
    // control shadow; output lag is absorbed by the repetitions below
    always_comb begin
        sh_d = sh_q;
        if (awvalid && awready && wvalid && wready && wstrb[0] && awaddr == ADDR_CONTROL) begin
            sh_d = wdata[CTRL_W-1:0];
        end
    end
    always_ff @(posedge aclk) begin
        sh_q <= aresetn ? sh_d : CTRL_RESET;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_xtal_pin_off: assert property (xtal [*2] |-> ref_clock_pin_oe_n)
        else $error("pin driven in crystal mode");
    a_legacy_owns: assert property ((!xtal && !legacy_clock_out_select) [*2] |-> !ref_clock_pin_oe_n)
        else $error("legacy output not on pin");
    a_legacy_rate: assert property (@(posedge aclk)
        disable iff (!aresetn || xtal || sleep_active || legacy_clock_out_select)
        (!legacy_clock_out_select) [*3] ##0 $rose(ref_clock_pin)
        |-> ##2 $fell(ref_clock_pin) ##2 $rose(ref_clock_pin))
        else $error("legacy pin not clock/4");
    a_pin_routes: assert property ((!xtal && legacy_clock_out_select && $stable(sh_q)) [*3]
        |-> ref_clock_pin_oe_n == !(sh_q[CTRL_EN_BIT] && sh_q[CTRL_OE_BIT]))
        else $error("pin enable wrong");
    a_off_quiet: assert property ((!sh_q[CTRL_EN_BIT]) [*3] |-> !ref_mod_clock)
        else $error("clock runs while disabled");
    a_zero_duty: assert property ((sh_q[CTRL_DC_LSB +: DC_W] == DUTY_0) [*3] |-> !ref_mod_clock)
        else $error("clock high at zero duty");
    a_slew_match: assert property ($stable(sh_q) [*2] |-> ref_slew_limit_enable == sh_q[CTRL_SLR_BIT])
        else $error("slew output wrong");
    a_sleep_hold: assert property (sleep_active [*2] |-> $stable(ref_mod_clock))
        else $error("clock moved in sleep");
    c_legacy: cover property ((!xtal && !legacy_clock_out_select) ##1 $rose(ref_clock_pin));
    c_xtal_mod: cover property (xtal ##1 $rose(ref_mod_clock));
    c_sleep: cover property (sleep_active [*4]);
endmodule
`default_nettype wire

//--- verif/rcd_load_model.sv
/* load on the pin and the modulator input: counts high samples
   assumes a released pin is pulled low by the load */
`timescale 1ns/1ps
`default_nettype none
module rcd_load_model (
    // clock, reset, count restart
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clear,
    // observed signals
    input wire logic ref_clock_pin,
    input wire logic ref_clock_pin_oe_n,
    input wire logic ref_mod_clock,
    // counts
    output logic [15:0] mod_high_q,
    output logic [15:0] pin_high_q
);
    logic [15:0] mod_high_d;
    logic [15:0] pin_high_d;
    // a released pin counts low, never as its last value
    always_comb begin
        mod_high_d = clear ? 16'h0 : mod_high_q + 16'(ref_mod_clock);
        pin_high_d = clear ? 16'h0 : pin_high_q + 16'(ref_clock_pin && !ref_clock_pin_oe_n);
    end
    always_ff @(posedge aclk) begin
        mod_high_q <= aresetn ? mod_high_d : 16'h0;
        pin_high_q <= aresetn ? pin_high_d : 16'h0;
    end
endmodule
`default_nettype wire

//--- verif/tb_reference_clock_divider.sv
/* self-checking bench for rcd_top with load model and checker
   assumes every bus request is answered well within the timeout */
`timescale 1ns/1ps
`default_nettype none
module tb_reference_clock_divider;
    import rcd_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic clear = 1'b0;
    logic [ADDR_W-1:0] awaddr = 8'h00;
    logic [ADDR_W-1:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic [2:0] xtal_sel = 3'h0;
    logic legacy_clock_out_select = 1'b1;
    logic sleep_active = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, oe, lvl;
    logic ref_clock_pin, ref_clock_pin_oe_n, ref_slew_limit_enable, ref_mod_clock;
    logic [1:0] bresp, rresp, rs, dc;
    logic [31:0] rdata, rd;
    logic [15:0] mod_high_q, pin_high_q;
    logic [2:0] dv;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed = 16;

    rcd_top dut_u (
        .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready,
        .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
        .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
        .low_power_crystal_mode(xtal_sel[0]), .standard_crystal_mode(xtal_sel[1]),
        .high_speed_crystal_mode(xtal_sel[2]), .legacy_clock_out_select, .sleep_active,
        .ref_clock_pin, .ref_clock_pin_oe_n, .ref_slew_limit_enable, .ref_mod_clock
    );
    rcd_load_model model_u (
        .aclk, .aresetn, .clear, .ref_clock_pin, .ref_clock_pin_oe_n, .ref_mod_clock,
        .mod_high_q, .pin_high_q
    );
    ////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    initial begin
        forever #5 aclk = ~aclk;
    end
    // hang guard, far above the few thousand cycles needed
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask
    // 4N samples at c quarters of duty give N*c highs
    function automatic logic [15:0] exp_high(input logic [2:0] d, input logic [1:0] c);
        return 16'(c) << d;
    endfunction
    // one transfer, write when wr; readies settle after an edge and hold to the next
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic [1:0] r);
        logic pa, pw, ta, tw, tv, done;
        pa = 1'b1;
        pw = wr;
        done = 1'b0;
        @(posedge aclk);
        awvalid <= wr;
        wvalid <= wr;
        bready <= wr;
        arvalid <= !wr;
        rready <= !wr;
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        while (!done) begin
            #1;
            ta = pa && (wr ? awready : arready);
            tw = pw && wready;
            tv = wr ? bvalid : rvalid;
            q = rdata;
            r = wr ? bresp : rresp;
            @(posedge aclk);
            if (ta) begin
                awvalid <= 1'b0;
                arvalid <= 1'b0;
                pa = 1'b0;
            end
            if (tw) begin
                wvalid <= 1'b0;
                pw = 1'b0;
            end
            if (tv) begin
                bready <= 1'b0;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    // count highs over n cycles; restart point not aligned to the wave
    task automatic count(input int n);
        clear <= 1'b1;
        @(posedge aclk);
        clear <= 1'b0;
        repeat (n) @(posedge aclk);
        #1;
    endtask
    task automatic measure(input logic [7:0] ctl, input logic [15:0] em, input logic [15:0] ep);
        bus(1'b1, ADDR_CONTROL, {24'h0, ctl}, rd, rs);
        repeat ((2 << ctl[2:0]) + 4) @(posedge aclk);
        count(4 << ctl[2:0]);
        check("mod highs", {16'h0, em}, {16'h0, mod_high_q});
        check("pin highs", {16'h0, ep}, {16'h0, pin_high_q});
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        bus(1'b0, ADDR_CONTROL, 32'h0, rd, rs);
        check("control reset", {24'h0, CTRL_RESET}, rd);
        check("slew reset", 32'h1, {31'h0, ref_slew_limit_enable});
        bus(1'b1, ADDR_CONTROL, 32'hFFFFFFFF, rd, rs);
        bus(1'b0, ADDR_CONTROL, 32'h0, rd, rs);
        check("control layout", 32'h000000FF, rd);
        bus(1'b1, 8'h0C, 32'h0, rd, rs);
        check("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, rs});
        bus(1'b0, 8'h0C, 32'h0, rd, rs);
        check("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, rs});
        bus(1'b1, ADDR_CONTROL, 32'h0, rd, rs);
        repeat (3) @(posedge aclk);
        #1;
        check("slew off", 32'h0, {31'h0, ref_slew_limit_enable});
        // every ratio but undivided twice, random duty (div-by-2 held at 50 %) and pin enable, zero duty fixed at div-by-8
        for (int k = 0; k < 14; k++) begin
            dv = 3'(k % 7 + 1);
            dc = (dv == DIV_BY_2) ? DUTY_50 : (k == 1) ? DUTY_25 : (k == 8) ? DUTY_75 :
                 (k == 9) ? DUTY_0 : 2'($random(seed));
            oe = 1'($random(seed));
            measure({1'b1, oe, 1'b1, dc, dv}, exp_high(dv, dc), oe ? exp_high(dv, dc) : 16'h0);
        end
        // undivided: pin follows the system clock
        bus(1'b1, ADDR_CONTROL, 32'h000000C8, rd, rs);
        repeat (3) @(posedge aclk);
        #2;
        check("undivided high", 32'h1, {31'h0, ref_clock_pin});
        #5;
        check("undivided low", 32'h0, {31'h0, ref_clock_pin});
        measure(8'hC0, 16'h0, 16'h0);
        measure(8'h53, 16'h0, 16'h0);
        for (int i = 0; i < 3; i++) begin
            xtal_sel <= 3'(1 << i);
            measure(8'hD2, exp_high(3'h2, DUTY_50), 16'h0);
        end
        // status is read-only: a write answers okay and changes nothing
        bus(1'b1, ADDR_STATUS, 32'hFFFFFFFF, rd, rs);
        check("status write resp", {30'h0, RESP_OKAY}, {30'h0, rs});
        bus(1'b0, ADDR_CONTROL, 32'h0, rd, rs);
        check("status write kept", 32'h000000D2, rd);
        bus(1'b0, ADDR_STATUS, 32'h0, rd, rs);
        check("status owner", (32'h1 << STAT_PIN_OSC_BIT) | (32'h1 << STAT_RUN_BIT),
              rd & ~(32'h1 << STAT_LEVEL_BIT));
        xtal_sel <= 3'h0;
        legacy_clock_out_select <= 1'b0;
        measure(8'hCB, exp_high(3'h3, DUTY_25), 16'h10);
        legacy_clock_out_select <= 1'b1;
        // sleep at an odd phase: the level stands wherever it was
        bus(1'b1, ADDR_CONTROL, 32'h000000D3, rd, rs);
        repeat (20) @(posedge aclk);
        #1;
        lvl = ref_mod_clock;
        @(posedge aclk);
        sleep_active <= 1'b1;
        repeat (3) @(posedge aclk);
        count(16);
        check("frozen highs", {27'h0, lvl, 4'h0}, {16'h0, mod_high_q});
        sleep_active <= 1'b0;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        bus(1'b0, ADDR_CONTROL, 32'h0, rd, rs);
        check("control rereset", {24'h0, CTRL_RESET}, rd);
        check("pin released", 32'h1, {31'h0, ref_clock_pin_oe_n});
        end_of_test();
    end
endmodule

bind rcd_top rcd_top_sva sva_u (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .low_power_crystal_mode, .standard_crystal_mode, .high_speed_crystal_mode,
    .legacy_clock_out_select, .sleep_active, .ref_clock_pin, .ref_clock_pin_oe_n,
    .ref_slew_limit_enable, .ref_mod_clock
);
`default_nettype wire
